// file: design/cmt_defs.vh
// Constants of the coil message command translator.
`ifndef CMT_DEFS_VH
`define CMT_DEFS_VH

// ----------------------------------------
// Operation codes and bus function codes
// ----------------------------------------
`define CMT_OP_WR 16'h0065
`define CMT_OP_RD 16'h0066
`define CMT_FN_WR 8'h0f
`define CMT_FN_RD 8'h01

// ----------------------------------------
// Status codes written to the second word
// ----------------------------------------
`define CMT_ST_OK 16'h0000
`define CMT_ST_OPC 16'h0001
`define CMT_ST_CNT 16'h0002
`define CMT_ST_OFF 16'h0003
`define CMT_ST_EXC 16'h0100

// ----------------------------------------
// Register offsets and reset values
// ----------------------------------------
`define CMT_REG_CTRL 4'h0
`define CMT_REG_IST 4'h1
`define CMT_REG_IMSK 4'h2
`define CMT_REG_LAST 4'h3
`define CMT_CTRL_RST 1'b1
`define CMT_IMSK_RST 2'h0

// ----------------------------------------
// Field positions
// ----------------------------------------
`define CMT_IRQ_DONE 0
`define CMT_IRQ_ERR 1

// ----------------------------------------
// Sizes
// ----------------------------------------
`define CMT_MAX_WORDS 100
`define CMT_WORD_BITS 16

`endif

// file: design/cmt_top.v
// Coil write and coil read command translator with its register port.
//
// The register offsets and the plain strobed port were chosen for this implementation.
`timescale 1ns/1ps
`default_nettype none
`include "cmt_defs.vh"
// What this block does
// R1: Opcode 101 sends a function 15 multiple coil write request.
// R2: Write coils start at the first data word's most significant bit.
// R3: After sixteen bits continue at the next word's most significant bit.
// R4: Coil count comes from word three, starting coil from word four.
// R5: The same coil count sets request size for write and read.
// R6: Opcode 102 sends a function 1 coil read, bits go to data.
// R7: Read bits packed MSB first, positions past the count cleared.
// R8: Network target: word five holds slot high, unit index low.
// R9: Serial target: word six holds drop count high, first drop low.
// R10: Drops two to seven come from words seven to nine, beyond count zero.
// R11: Network address octets are the low bytes of words six to nine.
// R12: Outcome is written to word two, zero success, else error code.
module cmt_top #(
	parameter MAX_WORDS = `CMT_MAX_WORDS,
	parameter AW = 7
) (
	// Clock and reset.
	input wire i_clk,
	input wire i_srst,
	// Control block from the PLC logic.
	input wire i_start,
	input wire i_serial,
	input wire [15:0] i_ctl_op,
	input wire [15:0] i_ctl_cnt,
	input wire [15:0] i_ctl_coil,
	input wire [15:0] i_ctl_w5,
	input wire [15:0] i_ctl_w6,
	input wire [15:0] i_ctl_w7,
	input wire [15:0] i_ctl_w8,
	input wire [15:0] i_ctl_w9,
	// Status word back to the PLC logic.
	output wire o_sts_wr,
	output wire [15:0] o_sts_val,
	// PLC data area port.
	output wire o_dat_rd,
	output wire o_dat_wr,
	output wire [AW-1:0] o_dat_addr,
	output wire [15:0] o_dat_wdata,
	input wire [15:0] i_dat_rdata,
	// Request to the bus engine.
	output wire o_req_valid,
	output wire [7:0] o_req_fn,
	output wire [15:0] o_req_coil,
	output wire [15:0] o_req_qty,
	output wire o_req_serial,
	output wire [7:0] o_req_slot,
	output wire [7:0] o_req_unit,
	output wire [31:0] o_req_ip,
	output wire [7:0] o_req_drop_n,
	output wire [55:0] o_req_drops,
	// Coil bits to and from the bus engine.
	output wire o_cbit_valid,
	output wire o_cbit,
	input wire i_rbit_valid,
	input wire i_rbit,
	input wire i_rsp_valid,
	input wire [7:0] i_rsp_exc,
	// Register port.
	input wire [3:0] i_reg_addr,
	input wire [15:0] i_reg_wdata,
	input wire i_reg_wr,
	input wire i_reg_rd,
	output wire [15:0] o_reg_rdata,
	// Interrupt.
	output wire o_irq
);

	// ----------------------------------------
	// States
	// ----------------------------------------
	localparam [6:0] S_IDLE = 7'h01;
	localparam [6:0] S_FETCH = 7'h02;
	localparam [6:0] S_LOAD = 7'h04;
	localparam [6:0] S_CAP = 7'h08;
	localparam [6:0] S_SHIFT = 7'h10;
	localparam [6:0] S_RBIT = 7'h20;
	localparam [6:0] S_WAIT = 7'h40;
	// The product is 32 bits wide; the count port only needs the low half.
	localparam [31:0] MAX_COILS_W = MAX_WORDS * `CMT_WORD_BITS;
	localparam [15:0] MAX_COILS = MAX_COILS_W[15:0];

	// Keeps a drop only when its position lies within the drop count.
	function [7:0] keep_drop;
		input [7:0] drop;
		input [7:0] n;
		input [7:0] pos;
		begin
			keep_drop = (pos <= n) ? drop : 8'h00;
		end
	endfunction

	reg [6:0] st_q;
	reg [15:0] rem_q;
	reg [3:0] pos_q;
	reg [AW-1:0] widx_q;
	reg [15:0] sreg_q;
	reg wr_op_q;
	reg sts_wr_q;
	reg [15:0] sts_val_q;
	reg dat_rd_q;
	reg dat_wr_q;
	reg [15:0] dat_wdata_q;
	reg req_q;
	reg [7:0] fn_q;
	reg [15:0] coil_q;
	reg [15:0] qty_q;
	reg ser_q;
	reg [7:0] slot_q;
	reg [7:0] unit_q;
	reg [31:0] ip_q;
	reg [7:0] drop_n_q;
	reg [55:0] drops_q;
	reg cbv_q;
	reg cb_q;
	reg en_q;
	reg [1:0] ist_q;
	reg [1:0] imsk_q;
	reg [15:0] rdata_q;
	reg irq_q;
	reg ev_done;
	reg ev_err;
	reg [1:0] ist_d;
	reg [15:0] rmerge;
	reg [15:0] rd_sel;
	wire [7:0] dn;

	// A network target has no route, so no drop may leak from word six.
	assign dn = i_serial ? i_ctl_w6[15:8] : 8'h00; // R9

	// Read bit merged into the word being packed, MSB first.
	always @*
	begin
		rmerge = sreg_q;
		rmerge[4'd15 - pos_q] = i_rbit; // R7
	end

	// ----------------------------------------
	// Command sequencer
	// ----------------------------------------
	// Accepts a control block, issues the request, moves coil bits.
	always @(posedge i_clk)
	begin
		req_q <= 1'b0;
		dat_rd_q <= 1'b0;
		dat_wr_q <= 1'b0;
		cbv_q <= 1'b0;
		sts_wr_q <= 1'b0;
		ev_done <= 1'b0;
		ev_err <= 1'b0;
		if (i_srst)
		begin
			st_q <= S_IDLE;
			rem_q <= 16'h0000;
			pos_q <= 4'h0;
			widx_q <= {AW{1'b0}};
			sreg_q <= 16'h0000;
			wr_op_q <= 1'b0;
			sts_val_q <= `CMT_ST_OK;
			dat_wdata_q <= 16'h0000;
			fn_q <= 8'h00;
			coil_q <= 16'h0000;
			qty_q <= 16'h0000;
			ser_q <= 1'b0;
			slot_q <= 8'h00;
			unit_q <= 8'h00;
			ip_q <= 32'h0000_0000;
			drop_n_q <= 8'h00;
			drops_q <= 56'h0;
			cb_q <= 1'b0;
		end
		else
		begin
			case (st_q)
			S_IDLE:
			begin
				if (i_start)
				begin
					pos_q <= 4'h0;
					widx_q <= {AW{1'b0}};
					sreg_q <= 16'h0000;
					rem_q <= i_ctl_cnt; // R4 R5
					qty_q <= i_ctl_cnt; // R5
					coil_q <= i_ctl_coil; // R4
					wr_op_q <= (i_ctl_op == `CMT_OP_WR);
					ser_q <= i_serial;
					slot_q <= i_ctl_w5[15:8]; // R8
					unit_q <= i_serial ? 8'h00 : i_ctl_w5[7:0]; // R8 R9
					ip_q <= {i_ctl_w6[7:0], i_ctl_w7[7:0],
						i_ctl_w8[7:0], i_ctl_w9[7:0]}; // R11
					drop_n_q <= dn; // R9
					drops_q <= {keep_drop(i_ctl_w6[7:0], dn, 8'd1),
						keep_drop(i_ctl_w7[15:8], dn, 8'd2),
						keep_drop(i_ctl_w7[7:0], dn, 8'd3),
						keep_drop(i_ctl_w8[15:8], dn, 8'd4),
						keep_drop(i_ctl_w8[7:0], dn, 8'd5),
						keep_drop(i_ctl_w9[15:8], dn, 8'd6),
						keep_drop(i_ctl_w9[7:0], dn, 8'd7)}; // R10
					if (!en_q)
					begin
						sts_val_q <= `CMT_ST_OFF; // R12
						sts_wr_q <= 1'b1;
						ev_err <= 1'b1;
					end
					else if (i_ctl_op != `CMT_OP_WR &&
						i_ctl_op != `CMT_OP_RD)
					begin
						sts_val_q <= `CMT_ST_OPC; // R12
						sts_wr_q <= 1'b1;
						ev_err <= 1'b1;
					end
					else if (i_ctl_cnt == 16'h0000 ||
						i_ctl_cnt > MAX_COILS)
					begin
						sts_val_q <= `CMT_ST_CNT; // R12
						sts_wr_q <= 1'b1;
						ev_err <= 1'b1;
					end
					else if (i_ctl_op == `CMT_OP_WR)
					begin
						fn_q <= `CMT_FN_WR; // R1
						req_q <= 1'b1;
						st_q <= S_FETCH;
					end
					else
					begin
						fn_q <= `CMT_FN_RD; // R6
						req_q <= 1'b1;
						st_q <= S_RBIT;
					end
				end
			end
			S_FETCH:
			begin
				dat_rd_q <= 1'b1;
				st_q <= S_LOAD;
			end
			S_LOAD:
				st_q <= S_CAP;
			S_CAP:
			begin
				sreg_q <= i_dat_rdata; // R2
				st_q <= S_SHIFT;
			end
			S_SHIFT:
			begin
				cbv_q <= 1'b1;
				cb_q <= sreg_q[15]; // R2
				sreg_q <= {sreg_q[14:0], 1'b0};
				rem_q <= rem_q - 16'h0001;
				pos_q <= pos_q + 4'h1;
				if (rem_q == 16'h0001)
					st_q <= S_WAIT;
				else if (pos_q == 4'hf)
				begin
					widx_q <= widx_q + {{(AW-1){1'b0}}, 1'b1}; // R3
					st_q <= S_FETCH;
				end
			end
			S_RBIT:
			begin
				if (i_rsp_valid)
				begin
					sts_val_q <= `CMT_ST_EXC | {8'h00, i_rsp_exc}; // R12
					sts_wr_q <= 1'b1;
					ev_err <= 1'b1;
					st_q <= S_IDLE;
				end
				else if (i_rbit_valid)
				begin
					rem_q <= rem_q - 16'h0001;
					pos_q <= pos_q + 4'h1;
					sreg_q <= rmerge;
					if (rem_q == 16'h0001 || pos_q == 4'hf)
					begin
						dat_wr_q <= 1'b1;
						dat_wdata_q <= rmerge; // R7
						sreg_q <= 16'h0000;
					end
					if (rem_q == 16'h0001)
						st_q <= S_WAIT;
				end
				if (dat_wr_q)
					widx_q <= widx_q + {{(AW-1){1'b0}}, 1'b1}; // R3
			end
			S_WAIT:
			begin
				if (i_rsp_valid)
				begin
					sts_val_q <= (i_rsp_exc == 8'h00) ? `CMT_ST_OK :
						(`CMT_ST_EXC | {8'h00, i_rsp_exc}); // R12
					sts_wr_q <= 1'b1;
					ev_done <= (i_rsp_exc == 8'h00);
					ev_err <= (i_rsp_exc != 8'h00);
					st_q <= S_IDLE;
				end
			end
			default:
				st_q <= S_IDLE;
			endcase
		end
	end

	// ----------------------------------------
	// Register port and interrupt
	// ----------------------------------------
	// Sticky events; a new event wins over a write-one clear.
	always @*
	begin
		ist_d = ist_q;
		if (i_reg_wr && i_reg_addr == `CMT_REG_IST)
			ist_d = ist_q & ~i_reg_wdata[1:0];
		ist_d[`CMT_IRQ_DONE] = ist_d[`CMT_IRQ_DONE] | ev_done;
		ist_d[`CMT_IRQ_ERR] = ist_d[`CMT_IRQ_ERR] | ev_err;
	end

	// Read data selection; unmapped offsets read zero.
	always @*
	begin
		case (i_reg_addr)
		`CMT_REG_CTRL: rd_sel = {15'h0000, en_q};
		`CMT_REG_IST: rd_sel = {14'h0000, ist_q};
		`CMT_REG_IMSK: rd_sel = {14'h0000, imsk_q};
		`CMT_REG_LAST: rd_sel = sts_val_q;
		default: rd_sel = 16'h0000;
		endcase
	end

	// Register updates, read data one cycle after the strobe.
	always @(posedge i_clk)
	begin
		if (i_srst)
		begin
			en_q <= `CMT_CTRL_RST;
			ist_q <= 2'h0;
			imsk_q <= `CMT_IMSK_RST;
			rdata_q <= 16'h0000;
			irq_q <= 1'b0;
		end
		else
		begin
			ist_q <= ist_d;
			if (i_reg_wr && i_reg_addr == `CMT_REG_CTRL)
				en_q <= i_reg_wdata[0];
			if (i_reg_wr && i_reg_addr == `CMT_REG_IMSK)
				imsk_q <= i_reg_wdata[1:0];
			rdata_q <= i_reg_rd ? rd_sel : 16'h0000;
			irq_q <= |(ist_d & imsk_q);
		end
	end

	// Outputs straight from flip-flops.
	assign o_sts_wr = sts_wr_q;
	assign o_sts_val = sts_val_q;
	assign o_dat_rd = dat_rd_q;
	assign o_dat_wr = dat_wr_q;
	assign o_dat_addr = widx_q;
	assign o_dat_wdata = dat_wdata_q;
	assign o_req_valid = req_q;
	assign o_req_fn = fn_q;
	assign o_req_coil = coil_q;
	assign o_req_qty = qty_q;
	assign o_req_serial = ser_q;
	assign o_req_slot = slot_q;
	assign o_req_unit = unit_q;
	assign o_req_ip = ip_q;
	assign o_req_drop_n = drop_n_q;
	assign o_req_drops = drops_q;
	assign o_cbit_valid = cbv_q;
	assign o_cbit = cb_q;
	assign o_reg_rdata = rdata_q;
	assign o_irq = irq_q;

endmodule // cmt_top
`default_nettype wire

// file: tb/cmt_chk.sv
// Assertion checker on the translator's ports.
`timescale 1ns/1ps
`default_nettype none
module cmt_chk (
	// Clock, reset and inputs.
	input wire i_clk,
	input wire i_srst,
	input wire [15:0] i_ctl_op,
	input wire [15:0] i_ctl_cnt,
	input wire [15:0] i_ctl_coil,
	input wire [15:0] i_ctl_w5,
	input wire [15:0] i_ctl_w6,
	input wire [15:0] i_ctl_w7,
	input wire [15:0] i_ctl_w8,
	input wire [15:0] i_ctl_w9,
	input wire [15:0] i_dat_rdata,
	input wire i_rsp_valid,
	input wire [7:0] i_rsp_exc,
	input wire i_reg_rd,
	// Outputs.
	input wire o_dat_rd,
	input wire o_req_valid,
	input wire [7:0] o_req_fn,
	input wire [15:0] o_req_coil,
	input wire [15:0] o_req_qty,
	input wire o_req_serial,
	input wire [7:0] o_req_slot,
	input wire [7:0] o_req_unit,
	input wire [31:0] o_req_ip,
	input wire [7:0] o_req_drop_n,
	input wire o_cbit_valid,
	input wire o_cbit,
	input wire o_sts_wr,
	input wire [15:0] o_sts_val,
	input wire [15:0] o_reg_rdata
);
	reg [79:0] w_q;
	reg [15:0] wd_q;
	reg [15:0] nb_q;
	reg rd_q;
	// Words of the start cycle, last fetched word and coil bits sent.
	always @(posedge i_clk)
	begin
		w_q <= {i_ctl_w5, i_ctl_w6, i_ctl_w7, i_ctl_w8, i_ctl_w9};
		rd_q <= o_dat_rd;
		if (rd_q)
			wd_q <= i_dat_rdata;
		nb_q <= o_req_valid ? 16'h0000 : nb_q + {15'h0000, o_cbit_valid};
	end
	default clocking cb @(posedge i_clk); endclocking
	default disable iff (i_srst);
	// A fetched word's top bit leaves first.
	sequence msb_s;
		##[2:4] (o_cbit_valid && o_cbit == wd_q[15]);
	endsequence
	req_fn_a: assert property (o_req_valid |->
		o_req_fn == ($past(i_ctl_op) == 16'h0065 ? 8'h0f : 8'h01))
		else $error("wrong function");
	req_size_a: assert property (o_req_valid |->
		o_req_qty == $past(i_ctl_cnt) && o_req_coil == $past(i_ctl_coil))
		else $error("wrong count or coil");
	net_addr_a: assert property (o_req_valid && !o_req_serial |->
		o_req_ip == {w_q[55:48], w_q[39:32], w_q[23:16], w_q[7:0]}
		&& o_req_unit == w_q[71:64]) else $error("wrong address");
	route_a: assert property (o_req_valid |->
		o_req_slot == w_q[79:72] &&
		o_req_drop_n == (o_req_serial ? w_q[63:56] : 8'h00))
		else $error("wrong route");
	coil_msb_a: assert property (o_dat_rd |-> msb_s)
		else $error("wrong first coil of word");
	coil_cnt_a: assert property (o_sts_wr && o_req_fn == 8'h0f &&
		o_sts_val == 16'h0000 |-> nb_q == o_req_qty)
		else $error("wrong coil count");
	rsp_sts_a: assert property (i_rsp_valid |=> o_sts_wr &&
		o_sts_val == ($past(i_rsp_exc) == 8'h00 ? 16'h0000
		: {8'h01, $past(i_rsp_exc)})) else $error("wrong status");
	rd_idle_a: assert property (!i_reg_rd |=> o_reg_rdata == 16'h0000)
		else $error("read data outside answer");
endmodule // cmt_chk
`default_nettype wire

// file: tb/cmt_plc_mem.sv
// Behavioural PLC data area on the block's word port.
`timescale 1ns/1ps
`default_nettype none
module cmt_plc_mem (
	// Clock and word port.
	input wire i_clk,
	input wire i_rd,
	input wire i_wr,
	input wire [6:0] i_addr,
	input wire [15:0] i_wdata,
	output logic [15:0] o_rdata
);
	logic [15:0] mem [0:99];
	initial o_rdata = 16'h0000;
	// An answer stands one cycle, then the bus shows its inverse.
	always @(posedge i_clk)
	begin
		o_rdata <= i_rd ? mem[i_addr] : ~o_rdata;
		if (i_wr)
			mem[i_addr] <= i_wdata;
	end
endmodule // cmt_plc_mem
`default_nettype wire

// file: tb/cmt_top_tb.sv
// Self-checking testbench of the coil command translator.
`timescale 1ns/1ps
`default_nettype none
module cmt_top_tb;
	logic i_clk, i_srst, i_start, i_serial, i_rbit_valid, i_rbit;
	logic i_rsp_valid, i_reg_wr, i_reg_rd;
	logic [15:0] i_ctl_op, i_ctl_cnt, i_ctl_coil, i_ctl_w5, i_ctl_w6;
	logic [15:0] i_ctl_w7, i_ctl_w8, i_ctl_w9, i_reg_wdata;
	logic [7:0] i_rsp_exc;
	logic [3:0] i_reg_addr;
	wire o_sts_wr, o_dat_rd, o_dat_wr, o_req_valid, o_req_serial, o_cbit;
	wire o_cbit_valid, o_irq;
	wire [15:0] o_sts_val, o_dat_wdata, o_req_coil, o_req_qty, o_reg_rdata;
	wire [15:0] i_dat_rdata;
	wire [6:0] o_dat_addr;
	wire [7:0] o_req_fn, o_req_slot, o_req_unit, o_req_drop_n;
	wire [31:0] o_req_ip;
	wire [55:0] o_req_drops;
	int mismatches, cmp_count, cyc;
	logic [31:0] got;
	cmt_top dut (
		.i_clk(i_clk), .i_srst(i_srst), .i_start(i_start),
		.i_serial(i_serial), .i_ctl_op(i_ctl_op), .i_ctl_cnt(i_ctl_cnt),
		.i_ctl_coil(i_ctl_coil), .i_ctl_w5(i_ctl_w5), .i_ctl_w6(i_ctl_w6),
		.i_ctl_w7(i_ctl_w7), .i_ctl_w8(i_ctl_w8), .i_ctl_w9(i_ctl_w9),
		.o_sts_wr(o_sts_wr), .o_sts_val(o_sts_val), .o_dat_rd(o_dat_rd),
		.o_dat_wr(o_dat_wr), .o_dat_addr(o_dat_addr),
		.o_dat_wdata(o_dat_wdata), .i_dat_rdata(i_dat_rdata),
		.o_req_valid(o_req_valid), .o_req_fn(o_req_fn),
		.o_req_coil(o_req_coil), .o_req_qty(o_req_qty),
		.o_req_serial(o_req_serial), .o_req_slot(o_req_slot),
		.o_req_unit(o_req_unit), .o_req_ip(o_req_ip),
		.o_req_drop_n(o_req_drop_n), .o_req_drops(o_req_drops),
		.o_cbit_valid(o_cbit_valid), .o_cbit(o_cbit),
		.i_rbit_valid(i_rbit_valid), .i_rbit(i_rbit),
		.i_rsp_valid(i_rsp_valid), .i_rsp_exc(i_rsp_exc),
		.i_reg_addr(i_reg_addr), .i_reg_wdata(i_reg_wdata),
		.i_reg_wr(i_reg_wr), .i_reg_rd(i_reg_rd),
		.o_reg_rdata(o_reg_rdata), .o_irq(o_irq));
	cmt_plc_mem u_mem (.i_clk(i_clk), .i_rd(o_dat_rd), .i_wr(o_dat_wr),
		.i_addr(o_dat_addr), .i_wdata(o_dat_wdata), .o_rdata(i_dat_rdata));
	// Clock of 25 ns and a hang limit.
	initial
	begin
		i_clk = 1'b0;
		forever #12.5 i_clk = ~i_clk;
	end
	always @(posedge i_clk)
	begin
		cyc <= cyc + 1;
		if (cyc == 2000)
		begin
			mismatches++;
			test_done();
		end
	end
	task test_done;
		if (mismatches == 0 && cmp_count > 0)
			$display("STATUS OK");
		else
			$display("STATUS NOT OK");
		$finish;
	endtask
	task chk(input logic [31:0] g, input logic [31:0] e);
		cmp_count++;
		if (g !== e)
		begin
			mismatches++;
			$display("Error %0t: got %h want %h", $time, g, e);
		end
	endtask
	task reg_wr(input logic [3:0] a, input logic [15:0] d);
		i_reg_addr <= a;
		i_reg_wdata <= d;
		i_reg_wr <= 1'b1;
		@(posedge i_clk);
		i_reg_wr <= 1'b0;
		@(posedge i_clk);
	endtask
	task reg_rd(input logic [3:0] a, input logic [15:0] e);
		i_reg_addr <= a;
		i_reg_rd <= 1'b1;
		@(posedge i_clk);
		i_reg_rd <= 1'b0;
		@(posedge i_clk);
		chk(o_reg_rdata, e);
	endtask
	// Pulses a command; returns when its first answer cycle is visible.
	task start(input logic [15:0] op, n, c, input logic [79:0] w,
		input logic s);
		{i_ctl_op, i_ctl_cnt, i_ctl_coil} <= {op, n, c};
		{i_ctl_w5, i_ctl_w6, i_ctl_w7, i_ctl_w8, i_ctl_w9} <= w;
		i_serial <= s;
		i_start <= 1'b1;
		@(posedge i_clk);
		i_start <= 1'b0;
		@(posedge i_clk);
	endtask
	task rsp(input logic [7:0] e, input logic [15:0] s);
		i_rsp_exc <= e;
		i_rsp_valid <= 1'b1;
		@(posedge i_clk);
		i_rsp_valid <= 1'b0;
		@(posedge i_clk);
		chk({o_sts_wr, o_sts_val}, {1'b1, s});
		@(posedge i_clk);
	endtask
	// Eighteen coils from two words, then the done interrupt.
	task t_write;
		u_mem.mem[0] = 16'ha164;
		u_mem.mem[1] = 16'h8000;
		reg_wr(4'h2, 16'h0001);
		start(16'h0065, 16'd18, 16'h0070, 80'h030a_00c0_00a8_0000_002c, 0);
		chk({o_req_valid, o_req_fn, o_req_slot, o_req_unit}, 'h10f030a);
		chk(o_req_ip, 32'hc0a8002c);
		got = 0;
		repeat (60)
		begin
			@(posedge i_clk);
			if (o_cbit_valid)
				got = {got[30:0], o_cbit};
		end
		chk(got, 32'h0002_8592);
		rsp(8'h00, 16'h0000);
		@(posedge i_clk);
		chk(o_irq, 1);
		reg_rd(4'h1, 16'h0001);
		reg_wr(4'h1, 16'h0001);
		reg_rd(4'h1, 16'h0000);
		chk(o_irq, 0);
	endtask
	// Four coils read over a serial route into a dirty word.
	task t_read;
		u_mem.mem[0] = 16'hffff;
		start(16'h0066, 16'd4, 16'h0006, 80'h0400_0202_68aa_1111_2222, 1);
		chk({o_req_valid, o_req_fn, o_req_drop_n, o_req_unit}, 'h1010200);
		chk(o_req_drops[55:24], 32'h0268_0000);
		chk(o_req_drops[31:0], 32'h0000_0000);
		for (int k = 0; k < 4; k++)
		begin
			i_rbit_valid <= 1'b1;
			i_rbit <= (k != 2);
			@(posedge i_clk);
		end
		i_rbit_valid <= 1'b0;
		repeat (3) @(posedge i_clk);
		rsp(8'h00, 16'h0000);
		chk(u_mem.mem[0], 32'h0000_d000);
	endtask
	// Refused commands answer with a code and no request; a bus exception
	// during a read aborts it with the exception status.
	task t_bad;
		start(16'h0067, 16'd1, 16'h0000, 80'h0, 0);
		chk({o_sts_wr, o_sts_val, o_req_valid}, 18'h2_0002);
		start(16'h0065, 16'd0, 16'h0000, 80'h0, 0);
		chk({o_sts_wr, o_sts_val, o_req_valid}, 18'h2_0004);
		reg_wr(4'h0, 16'h0000);
		start(16'h0065, 16'd1, 16'h0000, 80'h0, 0);
		chk({o_sts_wr, o_sts_val, o_req_valid}, 18'h2_0006);
		reg_rd(4'h1, 16'h0003);
		reg_wr(4'h0, 16'h0001);
		start(16'h0066, 16'd2, 16'h0000, 80'h0, 0);
		rsp(8'h02, 16'h0102);
	endtask
	initial
	begin
		i_srst = 1'b1;
		{i_start, i_serial, i_rbit_valid, i_rbit, i_rsp_valid} = '0;
		{i_reg_wr, i_reg_rd, i_rsp_exc, i_reg_addr, i_reg_wdata} = '0;
		{i_ctl_op, i_ctl_cnt, i_ctl_coil, i_ctl_w5, i_ctl_w6} = '0;
		{i_ctl_w7, i_ctl_w8, i_ctl_w9} = '0;
		repeat (12) @(posedge i_clk);
		i_srst <= 1'b0;
		@(posedge i_clk);
		reg_rd(4'h0, 16'h0001);
		reg_rd(4'h9, 16'h0000);
		t_write();
		t_read();
		t_bad();
		test_done();
	end
endmodule // cmt_top_tb
bind cmt_top cmt_chk u_chk (
	.i_clk(i_clk), .i_srst(i_srst), .i_ctl_op(i_ctl_op),
	.i_ctl_cnt(i_ctl_cnt), .i_ctl_coil(i_ctl_coil), .i_ctl_w5(i_ctl_w5),
	.i_ctl_w6(i_ctl_w6), .i_ctl_w7(i_ctl_w7), .i_ctl_w8(i_ctl_w8),
	.i_ctl_w9(i_ctl_w9), .i_dat_rdata(i_dat_rdata),
	.i_rsp_valid(i_rsp_valid), .i_rsp_exc(i_rsp_exc),
	.i_reg_rd(i_reg_rd), .o_dat_rd(o_dat_rd), .o_req_valid(o_req_valid),
	.o_req_fn(o_req_fn), .o_req_coil(o_req_coil), .o_req_qty(o_req_qty),
	.o_req_serial(o_req_serial), .o_req_slot(o_req_slot),
	.o_req_unit(o_req_unit), .o_req_ip(o_req_ip),
	.o_req_drop_n(o_req_drop_n), .o_cbit_valid(o_cbit_valid),
	.o_cbit(o_cbit), .o_sts_wr(o_sts_wr), .o_sts_val(o_sts_val),
	.o_reg_rdata(o_reg_rdata));
`default_nettype wire
